// ==== bench/system_options_watchdog_clkout_tb_top.sv ====
module system_options_watchdog_clkout_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sysopt_pkg::*;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
$display("[ERR] %s expected %h got %h", nm, e, g); end end

	logic        core_clk  = 1'b0;
	logic        rst       = 1'b1;
	logic        stop_exec = 1'b0;
	logic        port_data = 1'b0;
	logic        port_dir  = 1'b0;
	logic [31:0] haddr     = 32'h0;
	logic [31:0] hwdata    = 32'h0;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic        hsel      = 1'b0;
	logic [2:0]  hsize     = 3'h2;
	logic [7:0]  opt1;
	logic [7:0]  opt2;
	logic [31:0] rd;
	logic        pin;
	logic        oe_n;
	logic        sys_rst;
	logic        stop_ok;
	logic        tw_sel;
	logic        trg_sel;
	bit          lk1;
	bit          lk2;
	int          failures = 0;
	int          n_checks = 0;
	int          n;
	ahb_req_type req;
	ahb_rsp_type rsp;

	// the slave's hreadyout closes the loop as the bus hready
	assign req = {haddr, htrans, hwrite, hsize, hsel, rsp.hreadyout, hwdata};
	always #10 core_clk = ~core_clk;

	system_options_watchdog_clkout dut (
		.core_clk(core_clk), .rst(rst), .bus_req(req), .bus_rsp(rsp),
		.stop_exec(stop_exec), .port_data(port_data), .port_dir(port_dir),
		.shared_clkout_pin(pin), .shared_clkout_pin_oe_n(oe_n), .system_reset(sys_rst),
		.stop_allow(stop_ok), .twowire_pin_sel(tw_sel), .conv_trigger_sel(trg_sel)
	);

	// ==========================================
	// closing and bus tasks
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic wait_ready;
		int k;
		k = 0;
		@(posedge core_clk);
		while (rsp.hreadyout !== 1'b1)
		begin
			k++;
			if (k > 20)
			begin
				failures++;
				test_done();
			end
			@(posedge core_clk);
		end
	endtask : wait_ready

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsel   <= 1'b1;
		wait_ready();
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= {24'h0, d};
		wait_ready();
		rd = rsp.hrdata;
		if (wr && a == OFS_OPTIONS_ONE)
		begin
			if (!lk1)
				opt1 = d & OPTIONS_ONE_MASK;
			lk1 = 1;
		end
		if (wr && a == OFS_OPTIONS_TWO)
		begin
			opt2 = lk2 ? (opt2 & 8'hc0) | (d & 8'h17) : d & OPTIONS_TWO_MASK;
			lk2 = 1;
		end
	endtask : xfer

	task automatic rd_chk(input logic [7:0] a);
		logic [7:0] e;
		e = (a == OFS_OPTIONS_ONE) ? opt1 : (a == OFS_OPTIONS_TWO) ? opt2 : 8'h00;
		xfer(1'b0, a, 8'h00);
		`CHK("rdata", {24'h0, e}, rd)
	endtask : rd_chk

	// ==========================================
	// model helpers
	task do_reset;
		rst <= 1'b1;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		opt1 = OPTIONS_ONE_RESET;
		opt2 = OPTIONS_TWO_RESET;
		lk1 = 0;
		lk2 = 0;
		@(posedge core_clk);
	endtask : do_reset

	// cycles until a reset pulse is seen, lim when none
	task automatic count_rst(input int lim, output int c);
		c = 0;
		while (sys_rst !== 1'b1 && c < lim)
		begin
			@(posedge core_clk);
			c++;
		end
	endtask : count_rst

	task svc;
		xfer(1'b1, OFS_RESET_STATUS, SERVICE_FIRST);
		xfer(1'b1, OFS_RESET_STATUS, SERVICE_SECOND);
	endtask : svc

	task out_chk;
		`CHK("stop_allow", opt1[5], stop_ok)
		`CHK("twowire", opt1[3], tw_sel)
		`CHK("trigger", opt2[4], trg_sel)
	endtask : out_chk

	task stop_try(input logic exp);
		stop_exec <= 1'b1;
		@(posedge core_clk);
		stop_exec <= 1'b0;
		count_rst(6, n);
		`CHK("stop reset", exp, n < 6)
	endtask : stop_try

	task automatic period(output int c);
		c = 0;
		while (pin !== 1'b0 && c < 40)
		begin
			@(posedge core_clk);
			c++;
		end
		while (pin !== 1'b1 && c < 40)
		begin
			@(posedge core_clk);
			c++;
		end
		c = 0;
		do
		begin
			@(posedge core_clk);
			c++;
		end
		while (pin !== 1'b0 && c < 80);
		do
		begin
			@(posedge core_clk);
			c++;
		end
		while (pin !== 1'b1 && c < 80);
	endtask : period

	// ==========================================
	// main sequence
	initial
	begin
		void'($urandom(32'h53bb));
		do_reset();
		rd_chk(OFS_OPTIONS_ONE);
		rd_chk(OFS_OPTIONS_TWO);
		rd_chk(8'h0c);
		repeat (8)
		begin
			@(posedge core_clk);
			port_data <= 1'($urandom);
			port_dir  <= 1'($urandom);
			#1;
			`CHK("pin", port_data, pin)
			`CHK("oe_n", !port_dir, oe_n)
		end
		@(posedge core_clk);
		out_chk();
		stop_try(1'b1);
		xfer(1'b1, OFS_OPTIONS_ONE, 8'h68);
		xfer(1'b1, OFS_OPTIONS_ONE, 8'h00);
		rd_chk(OFS_OPTIONS_ONE);
		out_chk();
		stop_try(1'b0);
		xfer(1'b1, OFS_OPTIONS_TWO, 8'h93);
		for (int d = 1; d < 8; d++)
		begin
			xfer(1'b1, OFS_OPTIONS_TWO, 8'(d));
			rd_chk(OFS_OPTIONS_TWO);
			out_chk();
			period(n);
			`CHK("clk period", 2 * d, n)
			`CHK("oe_n on", 1'b0, oe_n)
		end
		xfer(1'b1, OFS_OPTIONS_TWO, 8'h50);
		rd_chk(OFS_OPTIONS_TWO);
		out_chk();
		#1;
		`CHK("pin off", port_data, pin)
		@(posedge core_clk);
		svc();
		repeat (2)
		begin
			count_rst(6000, n);
			`CHK("serviced", 6000, n)
			svc();
		end
		count_rst(8400, n);
		`CHK("overflow", 1'b1, n > 8185 && n < 8200)
		// second run, window mode
		do_reset();
		xfer(1'b1, OFS_OPTIONS_ONE, 8'h40);
		xfer(1'b1, OFS_OPTIONS_TWO, 8'hc0);
		xfer(1'b1, OFS_RESET_STATUS, SERVICE_FIRST);
		count_rst(6, n);
		`CHK("early write", 1'b1, n < 6)
		do_reset();
		xfer(1'b1, OFS_OPTIONS_ONE, 8'h40);
		xfer(1'b1, OFS_OPTIONS_TWO, 8'hc0);
		count_rst(6400, n);
		`CHK("window wait", 6400, n)
		svc();
		count_rst(8400, n);
		`CHK("window svc", 1'b1, n > 8185 && n < 8200)
		test_done();
	end
endmodule : system_options_watchdog_clkout_tb_top

// ==== core/sysopt_pkg.sv ====
// Functional notes
// - divide field zero keeps clock output off; pin stays under port control.
// - nonzero divide field drives divided bus clock on pin, overriding direction bit.
// - clock output frequency is bus clock over two times divide value.
// - first option register takes only first write after reset; always readable.
// - timeout field bits 7:6 plus clock select set watchdog timeout.
// - stop allow bit 5 gates stop; stop while clear forces illegal-opcode reset.
// - bit 3 routes two-wire pins: 0 first port pair, 1 alternate pair.
// - slow source codes 01,10,11 give 2^5,2^8,2^10 cycles; 00 disables.
// - bus source codes 01,10,11 give 2^13,2^16,2^18 bus cycles.
// - in window mode any reset-status write in first three quarters resets.
// - bus source window opens after 6144, 49152, 196608 counts.
// - clock select and window mode bits accept only one write after reset.
// - bit 4 picks converter trigger: 0 timer overflow, 1 interrupt pin.
// - bit 7 picks 1 kHz clock (0) or bus clock (1); bit 6 windows.
package sysopt_pkg;

	// ============================================================
	// register map (offsets chosen for this block)
	localparam logic [7:0]  OFS_OPTIONS_ONE   = 8'h00;
	localparam logic [7:0]  OFS_OPTIONS_TWO   = 8'h04;
	localparam logic [7:0]  OFS_RESET_STATUS  = 8'h08;
	localparam logic [7:0]  OPTIONS_ONE_RESET = 8'hc0;
	localparam logic [7:0]  OPTIONS_TWO_RESET = 8'h00;
	localparam logic [7:0]  OPTIONS_ONE_MASK  = 8'he8;
	localparam logic [7:0]  OPTIONS_TWO_MASK  = 8'hd7;
	localparam logic [7:0]  SERVICE_FIRST     = 8'h55;
	localparam logic [7:0]  SERVICE_SECOND    = 8'haa;

	// ============================================================
	// field positions
	localparam int TIMEOUT_HI   = 7;
	localparam int TIMEOUT_LO   = 6;
	localparam int STOP_BIT     = 5;
	localparam int TWOWIRE_BIT  = 3;
	localparam int CLKSEL_BIT   = 7;
	localparam int WINDOW_BIT   = 6;
	localparam int TRIGGER_BIT  = 4;
	localparam int DIVIDE_HI    = 2;

	// ============================================================
	// timing: slow source period and bus clock
	localparam int SLOW_PERIOD_US = 1000;
	localparam int BUS_PERIOD_NS  = 20;
	localparam int SLOW_TICK_CYC  = (SLOW_PERIOD_US * 1000) / BUS_PERIOD_NS;
	localparam logic [5:0] SLOW_EXP_1 = 6'd5;
	localparam logic [5:0] SLOW_EXP_2 = 6'd8;
	localparam logic [5:0] SLOW_EXP_3 = 6'd10;
	localparam logic [5:0] BUS_EXP_1  = 6'd13;
	localparam logic [5:0] BUS_EXP_2  = 6'd16;
	localparam logic [5:0] BUS_EXP_3  = 6'd18;

	typedef enum logic [1:0] {
		SVC_IDLE  = 2'b00,
		SVC_ARMED = 2'b01
	} svc_state_type;

	typedef struct packed {
		logic [7:0]    opt_one;
		logic          opt_one_locked;
		logic [7:0]    opt_two;
		logic          clksel_locked;
		logic          window_locked;
		svc_state_type svc;
		logic [18:0]   wdog_cnt;
		logic [15:0]   slow_div;
		logic [2:0]    clk_div;
		logic          clk_out;
		logic          rst_req;
		logic          ph_valid;
		logic          ph_write;
		logic [7:0]    ph_addr;
		logic [31:0]   rdata;
	} sysopt_state_type;

	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hsel;
		logic        hready;
		logic [31:0] hwdata;
	} ahb_req_type;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} ahb_rsp_type;

endpackage : sysopt_pkg

// ==== core/system_options_watchdog_clkout.sv ====
module system_options_watchdog_clkout
(
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire sysopt_pkg::ahb_req_type bus_req,
	output sysopt_pkg::ahb_rsp_type   bus_rsp,
	input  wire logic                 stop_exec,
	input  wire logic                 port_data,
	input  wire logic                 port_dir,
	output logic                      shared_clkout_pin,
	output logic                      shared_clkout_pin_oe_n,
	output logic                      system_reset,
	output logic                      stop_allow,
	output logic                      twowire_pin_sel,
	output logic                      conv_trigger_sel
);
	import sysopt_pkg::*;

	sysopt_state_type state_reg;
	sysopt_state_type state_next;

	// ============================================================
	// overflow exponent and window threshold
	function automatic logic [5:0] overflow_exp(input logic clksel, input logic [1:0] code);
		logic [5:0] e;
		e = 6'd0;
		case (code)
			2'b01: e = clksel ? BUS_EXP_1 : SLOW_EXP_1;
			2'b10: e = clksel ? BUS_EXP_2 : SLOW_EXP_2;
			2'b11: e = clksel ? BUS_EXP_3 : SLOW_EXP_3;
			default: e = 6'd0;
		endcase
		return e;
	endfunction : overflow_exp

	logic [1:0]  timeout_code;
	logic        wdog_on;
	logic        clksel;
	logic        wdog_tick;
	logic [18:0] overflow_cnt;
	logic [18:0] window_cnt;
	logic        wr_strobe;
	logic        rd_take;
	logic [7:0]  wbyte;
	logic [2:0]  divide;

	always_comb
	begin
		timeout_code = state_reg.opt_one[TIMEOUT_HI:TIMEOUT_LO];
		clksel       = state_reg.opt_two[CLKSEL_BIT];
		wdog_on      = (timeout_code != 2'b00);
		overflow_cnt = 19'(19'd1 << overflow_exp(clksel, timeout_code));
		// window opens at three quarters of the period
		window_cnt   = overflow_cnt - (overflow_cnt >> 2);
		wdog_tick    = clksel || (state_reg.slow_div == 16'(SLOW_TICK_CYC - 1));
		wr_strobe    = state_reg.ph_valid && state_reg.ph_write;
		rd_take      = bus_req.hsel && bus_req.hready && bus_req.htrans[1]
			&& !bus_req.hwrite;
		wbyte        = bus_req.hwdata[7:0];
		divide       = state_reg.opt_two[DIVIDE_HI:0];
	end

	// ============================================================
	// next state
	always_comb
	begin
		state_next = state_reg;
		state_next.rst_req = 1'b0;

		// address phase capture; zero wait states
		state_next.ph_valid = bus_req.hsel && bus_req.hready && bus_req.htrans[1];
		state_next.ph_write = bus_req.hwrite;
		state_next.ph_addr  = bus_req.haddr[7:0];

		if (rd_take)
		begin
			if (bus_req.haddr[7:0] == OFS_OPTIONS_ONE)
				state_next.rdata = {24'h000000, state_reg.opt_one};
			else if (bus_req.haddr[7:0] == OFS_OPTIONS_TWO)
				state_next.rdata = {24'h000000, state_reg.opt_two};
			else
				state_next.rdata = 32'h00000000;
		end

		// watchdog count
		state_next.slow_div = wdog_tick ? 16'h0000 : 16'(state_reg.slow_div + 16'h0001);
		if (!wdog_on)
			state_next.wdog_cnt = 19'h00000;
		else if (wdog_tick)
		begin
			if (state_reg.wdog_cnt >= overflow_cnt - 19'h00001)
			begin
				state_next.rst_req  = 1'b1;
				state_next.wdog_cnt = 19'h00000;
			end
			else
				state_next.wdog_cnt = 19'(state_reg.wdog_cnt + 19'h00001);
		end

		if (wr_strobe)
		begin
			if (state_reg.ph_addr == OFS_OPTIONS_ONE)
			begin
				if (!state_reg.opt_one_locked)
				begin
					state_next.opt_one        = wbyte & OPTIONS_ONE_MASK;
					state_next.opt_one_locked = 1'b1;
				end
			end
			else if (state_reg.ph_addr == OFS_OPTIONS_TWO)
			begin
				state_next.opt_two[TRIGGER_BIT]    = wbyte[TRIGGER_BIT];
				state_next.opt_two[DIVIDE_HI:0]    = wbyte[DIVIDE_HI:0];
				if (!state_reg.clksel_locked)
				begin
					state_next.opt_two[CLKSEL_BIT] = wbyte[CLKSEL_BIT];
					state_next.clksel_locked       = 1'b1;
				end
				if (!state_reg.window_locked)
				begin
					state_next.opt_two[WINDOW_BIT] = wbyte[WINDOW_BIT];
					state_next.window_locked       = 1'b1;
				end
			end
			else if (state_reg.ph_addr == OFS_RESET_STATUS)
			begin
				if (state_reg.opt_two[WINDOW_BIT] && wdog_on
					&& state_reg.wdog_cnt < window_cnt)
				begin
					state_next.rst_req = 1'b1;
					state_next.svc     = SVC_IDLE;
				end
				else
				begin
					case (state_reg.svc)
						SVC_IDLE:
							state_next.svc = (wbyte == SERVICE_FIRST) ? SVC_ARMED : SVC_IDLE;
						SVC_ARMED:
						begin
							if (wbyte == SERVICE_SECOND)
							begin
								state_next.wdog_cnt = 19'h00000;
								state_next.slow_div = 16'h0000;
							end
							state_next.svc = (wbyte == SERVICE_FIRST) ? SVC_ARMED : SVC_IDLE;
						end
						default:
							state_next.svc = SVC_IDLE;
					endcase
				end
			end
		end

		// stop without permission forces reset
		if (stop_exec && !state_reg.opt_one[STOP_BIT])
			state_next.rst_req = 1'b1;

		// clock output: toggle every divide bus cycles, period 2*divide
		if (divide == 3'b000)
		begin
			state_next.clk_div = 3'b000;
			state_next.clk_out = 1'b0;
		end
		else if (state_reg.clk_div >= divide - 3'b001)
		begin
			state_next.clk_div = 3'b000;
			state_next.clk_out = !state_reg.clk_out;
		end
		else
			state_next.clk_div = 3'(state_reg.clk_div + 3'b001);
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg                <= '0;
			state_reg.opt_one        <= OPTIONS_ONE_RESET;
			state_reg.opt_two        <= OPTIONS_TWO_RESET;
			state_reg.svc            <= SVC_IDLE;
		end
		else
			state_reg <= state_next;
	end

	// ============================================================
	// outputs
	always_comb
	begin
		bus_rsp.hrdata    = state_reg.rdata;
		bus_rsp.hreadyout = 1'b1;
		bus_rsp.hresp     = 1'b0;
		system_reset      = state_reg.rst_req;
		stop_allow        = state_reg.opt_one[STOP_BIT];
		twowire_pin_sel   = state_reg.opt_one[TWOWIRE_BIT];
		conv_trigger_sel  = state_reg.opt_two[TRIGGER_BIT];
		if (divide != 3'b000)
		begin
			shared_clkout_pin      = state_reg.clk_out;
			shared_clkout_pin_oe_n = 1'b0;
		end
		else
		begin
			shared_clkout_pin      = port_data;
			shared_clkout_pin_oe_n = !port_dir;
		end
	end

	// ============================================================
	// checks: register bus and write-once locks
	a_rsp_okay: assert property (@(posedge core_clk) disable iff (rst)
		bus_rsp.hreadyout && !bus_rsp.hresp && (bus_rsp.hrdata[31:8] == 24'h000000))
		else $error("bus response not ready and okay");

	a_rdata_one: assert property (@(posedge core_clk) disable iff (rst)
		(rd_take && bus_req.haddr[7:0] == OFS_OPTIONS_ONE)
		|=> (bus_rsp.hrdata == {24'h000000, $past(state_reg.opt_one)}))
		else $error("option register one read wrong");

	a_rdata_two: assert property (@(posedge core_clk) disable iff (rst)
		(rd_take && bus_req.haddr[7:0] == OFS_OPTIONS_TWO)
		|=> (bus_rsp.hrdata == {24'h000000, $past(state_reg.opt_two)}))
		else $error("option register two read wrong");

	a_rdata_none: assert property (@(posedge core_clk) disable iff (rst)
		(rd_take && bus_req.haddr[7:0] != OFS_OPTIONS_ONE
			&& bus_req.haddr[7:0] != OFS_OPTIONS_TWO)
		|=> (bus_rsp.hrdata == 32'h00000000))
		else $error("unmapped read not zero");

	a_lock_opt_one: assert property (@(posedge core_clk) disable iff (rst)
		$past(state_reg.opt_one_locked) |-> $stable(state_reg.opt_one))
		else $error("first option register changed after lock");

	a_lock_first: assert property (@(posedge core_clk) disable iff (rst)
		(wr_strobe && state_reg.ph_addr == OFS_OPTIONS_ONE && !state_reg.opt_one_locked)
		|=> state_reg.opt_one_locked)
		else $error("first write did not lock option register one");

	a_opt_one_mask: assert property (@(posedge core_clk) disable iff (rst)
		((state_reg.opt_one & ~OPTIONS_ONE_MASK) == 8'h00))
		else $error("reserved bit set in option register one");

	a_opt_two_mask: assert property (@(posedge core_clk) disable iff (rst)
		((state_reg.opt_two & ~OPTIONS_TWO_MASK) == 8'h00))
		else $error("reserved bit set in option register two");

	a_lock_clksel: assert property (@(posedge core_clk) disable iff (rst)
		$past(state_reg.clksel_locked) |-> $stable(state_reg.opt_two[CLKSEL_BIT]))
		else $error("clock select changed after lock");

	a_lock_window: assert property (@(posedge core_clk) disable iff (rst)
		$past(state_reg.window_locked) |-> $stable(state_reg.opt_two[WINDOW_BIT]))
		else $error("window bit changed after lock");

	a_lock_two_first: assert property (@(posedge core_clk) disable iff (rst)
		(wr_strobe && state_reg.ph_addr == OFS_OPTIONS_TWO && !state_reg.clksel_locked)
		|=> (state_reg.clksel_locked && state_reg.window_locked))
		else $error("first write did not lock watchdog bits");

	a_trigger_write: assert property (@(posedge core_clk) disable iff (rst)
		(wr_strobe && state_reg.ph_addr == OFS_OPTIONS_TWO)
		|=> (state_reg.opt_two[TRIGGER_BIT] == $past(wbyte[TRIGGER_BIT])))
		else $error("trigger select not rewritable");

	a_trigger_out: assert property (@(posedge core_clk) disable iff (rst)
		conv_trigger_sel == state_reg.opt_two[TRIGGER_BIT])
		else $error("trigger select output wrong");

	a_twowire_out: assert property (@(posedge core_clk) disable iff (rst)
		twowire_pin_sel == state_reg.opt_one[TWOWIRE_BIT])
		else $error("two-wire pin select output wrong");

	a_stop_out: assert property (@(posedge core_clk) disable iff (rst)
		stop_allow == state_reg.opt_one[STOP_BIT])
		else $error("stop allow output wrong");

	// ============================================================
	// checks: clock output
	a_clkout_off: assert property (@(posedge core_clk) disable iff (rst)
		(divide == 3'b000) |-> (shared_clkout_pin_oe_n == !port_dir))
		else $error("clock output active with zero divide");

	a_clkout_port: assert property (@(posedge core_clk) disable iff (rst)
		(divide == 3'b000) |-> (shared_clkout_pin == port_data))
		else $error("pin not under port control");

	a_clkout_idle: assert property (@(posedge core_clk) disable iff (rst)
		(divide == 3'b000) |=> !state_reg.clk_out)
		else $error("clock output not parked low");

	a_clkout_drive: assert property (@(posedge core_clk) disable iff (rst)
		(divide != 3'b000) |-> !shared_clkout_pin_oe_n)
		else $error("clock output not driven");

	a_clkout_value: assert property (@(posedge core_clk) disable iff (rst)
		(divide != 3'b000) |-> (shared_clkout_pin == state_reg.clk_out))
		else $error("pin does not carry divided clock");

	a_clkout_div1: assert property (@(posedge core_clk) disable iff (rst)
		(divide == 3'b001 && $past(divide) == 3'b001) |-> $changed(state_reg.clk_out))
		else $error("divide by two clock does not toggle");

	a_clkout_hold: assert property (@(posedge core_clk) disable iff (rst)
		(divide != 3'b000 && state_reg.clk_div < divide - 3'b001)
		|=> $stable(state_reg.clk_out))
		else $error("clock output toggled early");

	a_clkout_toggle: assert property (@(posedge core_clk) disable iff (rst)
		(divide != 3'b000 && state_reg.clk_div >= divide - 3'b001)
		|=> $changed(state_reg.clk_out))
		else $error("clock output missed a toggle");

	// ============================================================
	// checks: watchdog and stop
	a_stop_reset: assert property (@(posedge core_clk) disable iff (rst)
		(stop_exec && !state_reg.opt_one[STOP_BIT]) |=> system_reset)
		else $error("illegal stop did not reset");

	a_wdog_off: assert property (@(posedge core_clk) disable iff (rst)
		!wdog_on |=> (state_reg.wdog_cnt == 19'h00000))
		else $error("watchdog counts while disabled");

	a_wdog_slow_hold: assert property (@(posedge core_clk) disable iff (rst)
		(wdog_on && !wdog_tick && !wr_strobe) |=> $stable(state_reg.wdog_cnt))
		else $error("watchdog counted without a tick");

	a_wdog_count: assert property (@(posedge core_clk) disable iff (rst)
		(wdog_on && clksel && !wr_strobe && state_reg.wdog_cnt < overflow_cnt - 19'h00001)
		|=> (state_reg.wdog_cnt == 19'($past(state_reg.wdog_cnt) + 19'h00001)))
		else $error("bus source watchdog did not count");

	a_wdog_overflow: assert property (@(posedge core_clk) disable iff (rst)
		(wdog_on && clksel && state_reg.wdog_cnt == overflow_cnt - 19'h00001
			&& !wr_strobe && !stop_exec) |=> system_reset)
		else $error("overflow without reset");

	a_overflow_clear: assert property (@(posedge core_clk) disable iff (rst)
		(wdog_on && wdog_tick && !wr_strobe && state_reg.wdog_cnt >= overflow_cnt - 19'h00001)
		|=> (state_reg.wdog_cnt == 19'h00000))
		else $error("counter not restarted at overflow");

	a_svc_arm: assert property (@(posedge core_clk) disable iff (rst)
		(wr_strobe && state_reg.ph_addr == OFS_RESET_STATUS && wbyte == SERVICE_FIRST
			&& !(state_reg.opt_two[WINDOW_BIT] && wdog_on && state_reg.wdog_cnt < window_cnt))
		|=> (state_reg.svc == SVC_ARMED))
		else $error("first service pattern did not arm");

	a_service_clear: assert property (@(posedge core_clk) disable iff (rst)
		(wr_strobe && state_reg.ph_addr == OFS_RESET_STATUS && state_reg.svc == SVC_ARMED
			&& wbyte == SERVICE_SECOND
			&& !(state_reg.opt_two[WINDOW_BIT] && wdog_on && state_reg.wdog_cnt < window_cnt))
		|=> (state_reg.wdog_cnt == 19'h00000))
		else $error("service sequence did not restart counter");

	a_window_early: assert property (@(posedge core_clk) disable iff (rst)
		(wr_strobe && state_reg.ph_addr == OFS_RESET_STATUS && wdog_on
			&& state_reg.opt_two[WINDOW_BIT] && state_reg.wdog_cnt < window_cnt)
		|=> system_reset)
		else $error("early service write did not reset");

	a_window_open: assert property (@(posedge core_clk) disable iff (rst)
		(wr_strobe && state_reg.ph_addr == OFS_RESET_STATUS && wdog_on
			&& state_reg.opt_two[WINDOW_BIT] && state_reg.wdog_cnt >= window_cnt
			&& state_reg.wdog_cnt != overflow_cnt - 19'h00001 && !stop_exec)
		|=> !system_reset)
		else $error("service write inside window reset the system");

endmodule : system_options_watchdog_clkout
